// file: design/bdtbs_top.sv
`timescale 1ns/100ps
// What this block does
// R1: Two-bit selector picks timing pair one to four.
// R2: Half-bridge n selector sits in bits 2n-1:2n-2.
// R3: Pair selector register resets to all zeros.
// R4: Pair selector decoded at offset 0x04, read/write.
// R5: Active timing register at offset 0x05, bank zero.
// R6: Bit 15 of timing register reads zero.
// R7: Five 3-bit time codes packed as documented.
// R8: Timing register resets to 0x4924.
// R9: Cross-current code decodes 375 ns to 16 us.
// R10: Blank code decodes 625 ns to 16 us.
// R11: Host keeps drive current low with 16 us delay.
// R12: Host keeps drive current low with 16 us blank.
// R13: Bank-zero times serve active switching only.
// R14: Bank one holds independent freewheel timing register.
// R15: Cross-current time is dead interval between switches.
// R16: Overvoltage ignored during blank time after switching.
module bdtbs_top (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire bdtbs_pkg::bdtbs_reg_req_t           regReq,
    input  wire bdtbs_pkg::bdtbs_ext_set_t           actExtCodes,
    input  wire bdtbs_pkg::bdtbs_ext_set_t           fwExtCodes,
    input  wire logic [bdtbs_pkg::NUM_BRIDGES-1:0]   fwSel,
    input  wire logic [bdtbs_pkg::NUM_BRIDGES-1:0]   switchReq,
    input  wire logic [bdtbs_pkg::NUM_BRIDGES-1:0]   dsOvervoltage,
    input  wire logic [bdtbs_pkg::NUM_BRIDGES-1:0]   faultClear,
    output logic [bdtbs_pkg::DATA_W-1:0]             rdData_ff,
    output logic [bdtbs_pkg::NUM_BRIDGES-1:0]        deadActive_ff,
    output logic [bdtbs_pkg::NUM_BRIDGES-1:0]        blankActive_ff,
    output logic [bdtbs_pkg::NUM_BRIDGES-1:0]        dsFault_ff
);
    logic [bdtbs_pkg::DATA_W-1:0]       pairSel_ff;
    bdtbs_pkg::bdtbs_timing_set_t       actSet_ff;
    bdtbs_pkg::bdtbs_timing_set_t       fwSet_ff;
    logic [bdtbs_pkg::NUM_BRIDGES-1:0]  ovMeta_ff;
    logic [bdtbs_pkg::NUM_BRIDGES-1:0]  ovSync_ff;
    logic [bdtbs_pkg::CNT_W-1:0]        bridgeCcp   [bdtbs_pkg::NUM_BRIDGES];
    logic [bdtbs_pkg::CNT_W-1:0]        bridgeBlank [bdtbs_pkg::NUM_BRIDGES];
    logic                               wrPair;
    logic                               wrAct;
    logic                               wrFw;

    assign wrPair = regReq.wr && regReq.addr == bdtbs_pkg::PAIR_SEL_OFS; // R4
    assign wrAct  = regReq.wr && regReq.addr == bdtbs_pkg::TIMING_SET_OFS
                    && regReq.bank == bdtbs_pkg::BANK_ACTIVE; // R5
    assign wrFw   = regReq.wr && regReq.addr == bdtbs_pkg::TIMING_SET_OFS
                    && regReq.bank == bdtbs_pkg::BANK_FREEWHEEL; // R14

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pairSel_ff <= bdtbs_pkg::PAIR_SEL_RST; // R3
        end else if (wrPair) begin
            pairSel_ff <= regReq.data; // R2
        end
    end

    // Bit 15 is not stored at all, so it can never read back as one.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            actSet_ff <= bdtbs_pkg::TIMING_SET_RST[bdtbs_pkg::RSVD_BIT-1:0]; // R8
        end else if (wrAct) begin
            actSet_ff <= regReq.data[bdtbs_pkg::RSVD_BIT-1:0]; // R7
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fwSet_ff <= bdtbs_pkg::TIMING_SET_RST[bdtbs_pkg::RSVD_BIT-1:0];
        end else if (wrFw) begin
            fwSet_ff <= regReq.data[bdtbs_pkg::RSVD_BIT-1:0]; // R14
        end
    end

    // Unmapped offsets read as zero; data holds between reads.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData_ff <= '0;
        end else if (regReq.rd) begin
            case (regReq.addr)
                bdtbs_pkg::PAIR_SEL_OFS: begin
                    rdData_ff <= pairSel_ff; // R4
                end
                bdtbs_pkg::TIMING_SET_OFS: begin
                    if (regReq.bank == bdtbs_pkg::BANK_ACTIVE) begin
                        rdData_ff <= {1'b0, actSet_ff}; // R6
                    end else begin
                        rdData_ff <= {1'b0, fwSet_ff}; // R14
                    end
                end
                default: begin
                    rdData_ff <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovMeta_ff <= '0;
            ovSync_ff <= '0;
        end else begin
            ovMeta_ff <= dsOvervoltage;
            ovSync_ff <= ovMeta_ff;
        end
    end

    // Each bridge picks its pair, then the active or freewheel set.
    always_comb begin
        bdtbs_pkg::bdtbs_codes_t codes;
        codes = '0;
        for (int n = 0; n < bdtbs_pkg::NUM_BRIDGES; n++) begin
            if (fwSel[n]) begin
                codes = bdtbs_pkg::pick_codes(pairSel_ff[n*bdtbs_pkg::SEL_W +: bdtbs_pkg::SEL_W],
                                              fwSet_ff, fwExtCodes); // R14
            end else begin
                codes = bdtbs_pkg::pick_codes(pairSel_ff[n*bdtbs_pkg::SEL_W +: bdtbs_pkg::SEL_W],
                                              actSet_ff, actExtCodes); // R1 R13
            end
            bridgeCcp[n]   = bdtbs_pkg::ccp_cycles(codes.ccp); // R9
            bridgeBlank[n] = bdtbs_pkg::blank_cycles(codes.blank); // R10
        end
    end

    for (genvar g = 0; g < bdtbs_pkg::NUM_BRIDGES; g++) begin : gBridge
        bdtbs_switch_timer uTimer (
            .ref_clk        (ref_clk),
            .rst_n          (rst_n),
            .switchReq      (switchReq[g]),
            .ccpCycles      (bridgeCcp[g]),
            .blankCycles    (bridgeBlank[g]),
            .ovIn           (ovSync_ff[g]),
            .faultClear     (faultClear[g]),
            .deadActive_ff  (deadActive_ff[g]),
            .blankActive_ff (blankActive_ff[g]),
            .faultFlag_ff   (dsFault_ff[g])
        );
    end

    AST_PAIR_RESET: assert property (@(posedge ref_clk) // R3
        !rst_n |=> pairSel_ff == bdtbs_pkg::PAIR_SEL_RST)
        else $error("pair selector not zero after reset");

    AST_SET_RESET: assert property (@(posedge ref_clk) // R8
        !rst_n |=> {1'b0, actSet_ff} == bdtbs_pkg::TIMING_SET_RST)
        else $error("active timing set wrong after reset");

    AST_PAIR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        (wrPair && !regReq.rd) ##1 regReq.rd && regReq.addr == bdtbs_pkg::PAIR_SEL_OFS
        |=> rdData_ff == $past(regReq.data, 2))
        else $error("pair selector write not read back");

    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        regReq.rd && regReq.addr == bdtbs_pkg::TIMING_SET_OFS |=> !rdData_ff[bdtbs_pkg::RSVD_BIT])
        else $error("reserved bit read as one");

    AST_BANK_SPLIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        wrFw |=> actSet_ff == $past(actSet_ff))
        else $error("bank one write changed active set");

    AST_PAIR_FOUR: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        pairSel_ff[15:14] == bdtbs_pkg::PAIR_FOUR && !fwSel[7]
        |-> bridgeCcp[7] == bdtbs_pkg::ccp_cycles(actExtCodes.ccp4)
            && bridgeBlank[7] == bdtbs_pkg::blank_cycles(actExtCodes.blank4))
        else $error("bridge 8 pair four not selected");

    AST_PAIR_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        pairSel_ff[1:0] == bdtbs_pkg::PAIR_ONE && !fwSel[0]
        |-> bridgeCcp[0] == bdtbs_pkg::ccp_cycles(actSet_ff.ccp1))
        else $error("bridge 1 pair one not selected");

    AST_DECODE_EDGES: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        bdtbs_pkg::ccp_cycles(3'h0) == 12'h05e && bdtbs_pkg::ccp_cycles(3'h7) == 12'hfa0
        && bdtbs_pkg::blank_cycles(3'h0) == 12'h09d)
        else $error("time code decode wrong");

    AST_FW_RESET: assert property (@(posedge ref_clk) // R14
        !rst_n |=> {1'b0, fwSet_ff} == bdtbs_pkg::TIMING_SET_RST)
        else $error("freewheel timing set wrong after reset");

    AST_UNMAPPED_READ: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        regReq.rd && regReq.addr != bdtbs_pkg::PAIR_SEL_OFS && regReq.addr != bdtbs_pkg::TIMING_SET_OFS
        |=> rdData_ff == '0)
        else $error("unmapped offset did not read zero");

    AST_UNMAPPED_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        regReq.wr && regReq.addr != bdtbs_pkg::PAIR_SEL_OFS && regReq.addr != bdtbs_pkg::TIMING_SET_OFS
        |=> pairSel_ff == $past(pairSel_ff) && actSet_ff == $past(actSet_ff) && fwSet_ff == $past(fwSet_ff))
        else $error("write to unmapped offset changed a register");

    AST_FW_SPLIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        wrAct |=> fwSet_ff == $past(fwSet_ff))
        else $error("bank zero write changed freewheel set");

    // A swap of two fields in the struct would pass every read-back test, so this checks positions.
    AST_FIELD_PACK: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        wrAct |=> actSet_ff.ccp3 == $past(regReq.data[bdtbs_pkg::CCP3_LSB +: bdtbs_pkg::CODE_W])
            && actSet_ff.blank2 == $past(regReq.data[bdtbs_pkg::BLANK2_LSB +: bdtbs_pkg::CODE_W])
            && actSet_ff.ccp2 == $past(regReq.data[bdtbs_pkg::CCP2_LSB +: bdtbs_pkg::CODE_W])
            && actSet_ff.blank1 == $past(regReq.data[bdtbs_pkg::BLANK1_LSB +: bdtbs_pkg::CODE_W])
            && actSet_ff.ccp1 == $past(regReq.data[bdtbs_pkg::CCP1_LSB +: bdtbs_pkg::CODE_W]))
        else $error("timing code fields not packed in place");

    AST_BANK_READ: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        regReq.rd && regReq.addr == bdtbs_pkg::TIMING_SET_OFS && regReq.bank == bdtbs_pkg::BANK_ACTIVE
        |=> rdData_ff[bdtbs_pkg::RSVD_BIT-1:0] == $past(actSet_ff))
        else $error("bank zero read did not return active set");

    AST_PAIR_TWO: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        pairSel_ff[1:0] == bdtbs_pkg::PAIR_TWO && !fwSel[0]
        |-> bridgeBlank[0] == bdtbs_pkg::blank_cycles(actSet_ff.blank2))
        else $error("bridge 1 pair two not taken from active set");

    AST_FW_PICK: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        pairSel_ff[1:0] == bdtbs_pkg::PAIR_ONE && fwSel[0]
        |-> bridgeCcp[0] == bdtbs_pkg::ccp_cycles(fwSet_ff.ccp1))
        else $error("bridge 1 freewheel pair one not selected");

    AST_BLANK_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        bdtbs_pkg::blank_cycles(3'h2) == 12'h139 && bdtbs_pkg::blank_cycles(3'h7) == 12'hfa0)
        else $error("blank code decode wrong");

endmodule

// file: design/bdtbs_pkg.sv
package bdtbs_pkg;

    localparam int          CLK_MHZ      = 250;
    localparam int          NUM_BRIDGES  = 8;
    localparam int          SEL_W        = 2;
    localparam int          CODE_W       = 3;
    localparam int          CNT_W        = 12;
    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 16;

    localparam logic [ADDR_W-1:0] PAIR_SEL_OFS   = 5'h04;
    localparam logic [ADDR_W-1:0] TIMING_SET_OFS = 5'h05;
    localparam logic              BANK_ACTIVE    = 1'b0;
    localparam logic              BANK_FREEWHEEL = 1'b1;

    localparam logic [DATA_W-1:0] PAIR_SEL_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] TIMING_SET_RST = 16'h4924;

    // Field positions inside the timing set word.
    localparam int          CCP1_LSB     = 0;
    localparam int          BLANK1_LSB   = 3;
    localparam int          CCP2_LSB     = 6;
    localparam int          BLANK2_LSB   = 9;
    localparam int          CCP3_LSB     = 12;
    localparam int          RSVD_BIT     = 15;

    localparam logic [SEL_W-1:0] PAIR_ONE   = 2'h0;
    localparam logic [SEL_W-1:0] PAIR_TWO   = 2'h1;
    localparam logic [SEL_W-1:0] PAIR_THREE = 2'h2;
    localparam logic [SEL_W-1:0] PAIR_FOUR  = 2'h3;

    // Typical times in ns, indexed by the 3-bit code.
    localparam int CCP_NS   [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
    localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

    typedef struct packed {
        logic [CODE_W-1:0] ccp3;
        logic [CODE_W-1:0] blank2;
        logic [CODE_W-1:0] ccp2;
        logic [CODE_W-1:0] blank1;
        logic [CODE_W-1:0] ccp1;
    } bdtbs_timing_set_t;

    typedef struct packed {
        logic [CODE_W-1:0] blank4;
        logic [CODE_W-1:0] ccp4;
        logic [CODE_W-1:0] blank3;
    } bdtbs_ext_set_t;

    typedef struct packed {
        logic [CODE_W-1:0] ccp;
        logic [CODE_W-1:0] blank;
    } bdtbs_codes_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic              bank;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bdtbs_reg_req_t;

    // Minimum intervals, so the count rounds up.
    function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
        ns_to_cycles = CNT_W'((ns * CLK_MHZ + 999) / 1000);
    endfunction

    function automatic logic [CNT_W-1:0] ccp_cycles(input logic [CODE_W-1:0] code);
        ccp_cycles = ns_to_cycles(CCP_NS[code]);
    endfunction

    function automatic logic [CNT_W-1:0] blank_cycles(input logic [CODE_W-1:0] code);
        blank_cycles = ns_to_cycles(BLANK_NS[code]);
    endfunction

    function automatic bdtbs_codes_t pick_codes(input logic [SEL_W-1:0] sel,
                                                input bdtbs_timing_set_t s,
                                                input bdtbs_ext_set_t e);
        bdtbs_codes_t c;
        c = '{ccp: s.ccp1, blank: s.blank1};
        case (sel)
            PAIR_ONE:   c = '{ccp: s.ccp1, blank: s.blank1};
            PAIR_TWO:   c = '{ccp: s.ccp2, blank: s.blank2};
            PAIR_THREE: c = '{ccp: s.ccp3, blank: e.blank3};
            PAIR_FOUR:  c = '{ccp: e.ccp4, blank: e.blank4};
            default:    c = '{ccp: s.ccp1, blank: s.blank1};
        endcase
        pick_codes = c;
    endfunction

endpackage

// file: design/bdtbs_switch_timer.sv
`timescale 1ns/100ps
module bdtbs_switch_timer (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire logic                         switchReq,
    input  wire logic [bdtbs_pkg::CNT_W-1:0]  ccpCycles,
    input  wire logic [bdtbs_pkg::CNT_W-1:0]  blankCycles,
    input  wire logic                         ovIn,
    input  wire logic                         faultClear,
    output logic                              deadActive_ff,
    output logic                              blankActive_ff,
    output logic                              faultFlag_ff
);
    typedef enum logic [1:0] {ST_IDLE, ST_DEAD, ST_BLANK} bdtbs_tmr_state_t;

    bdtbs_tmr_state_t                 state_ff;
    bdtbs_tmr_state_t                 nxt_state;
    logic [bdtbs_pkg::CNT_W-1:0]      cnt_ff;
    logic [bdtbs_pkg::CNT_W-1:0]      nxt_cnt;
    logic [bdtbs_pkg::CNT_W-1:0]      blankLoad_ff;

    // A new switch request restarts the dead interval even mid-sequence.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (switchReq) begin
            nxt_state = ST_DEAD; // R15
            nxt_cnt   = ccpCycles - bdtbs_pkg::CNT_W'(1);
        end else begin
            case (state_ff)
                ST_DEAD: begin
                    if (cnt_ff == '0) begin
                        nxt_state = ST_BLANK; // R16
                        nxt_cnt   = blankLoad_ff - bdtbs_pkg::CNT_W'(1);
                    end else begin
                        nxt_cnt = cnt_ff - bdtbs_pkg::CNT_W'(1);
                    end
                end
                ST_BLANK: begin
                    if (cnt_ff == '0) begin
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_cnt = cnt_ff - bdtbs_pkg::CNT_W'(1);
                    end
                end
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff       <= ST_IDLE;
            cnt_ff         <= '0;
            deadActive_ff  <= 1'b0;
            blankActive_ff <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            cnt_ff         <= nxt_cnt;
            deadActive_ff  <= (nxt_state == ST_DEAD);
            blankActive_ff <= (nxt_state == ST_BLANK);
        end
    end

    // The blank length is captured with the request so a register write mid-sequence cannot shorten it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blankLoad_ff <= bdtbs_pkg::CNT_W'(1);
        end else if (switchReq) begin
            blankLoad_ff <= blankCycles;
        end
    end

    // Overvoltage counts only outside dead and blank time; a set beats a clear.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            faultFlag_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && !switchReq && ovIn) begin
            faultFlag_ff <= 1'b1; // R16
        end else if (faultClear) begin
            faultFlag_ff <= 1'b0;
        end
    end

    AST_DEAD_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        switchReq |=> deadActive_ff && cnt_ff == $past(ccpCycles) - bdtbs_pkg::CNT_W'(1))
        else $error("dead interval not loaded from selected time");

    AST_DEAD_TO_BLANK: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        (state_ff == ST_DEAD && cnt_ff == '0 && !switchReq) |=> blankActive_ff && !deadActive_ff)
        else $error("blank time did not follow dead interval");

    AST_BLANK_MASKS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        (state_ff != ST_IDLE && !faultFlag_ff) |=> !faultFlag_ff)
        else $error("fault flagged during dead or blank time");

    AST_FAULT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        (state_ff == ST_IDLE && !switchReq && ovIn) |=> faultFlag_ff)
        else $error("overvoltage outside blank time not flagged");

endmodule

// file: sim/bdtbs_host_model.sv
`timescale 1ns/100ps
module bdtbs_host_model (
    input  wire logic                 ref_clk,
    output bdtbs_pkg::bdtbs_reg_req_t regReq
);
    initial regReq = '0;

    // Requests change on the falling edge and stand through one rising edge, so the block samples settled values.
    // The model never writes a drive current, so 16 us codes carry no current cap here.
    task automatic access(input logic w, input logic bank, input logic [4:0] addr, input logic [15:0] data);
        @(negedge ref_clk);
        regReq = '{wr: w, rd: !w, bank: bank, addr: addr, data: data};
        @(negedge ref_clk);
        regReq = '0;
    endtask

    // A write followed at once by a read of the same offset, the tightest legal spacing.
    task automatic write_read(input logic bank, input logic [4:0] addr, input logic [15:0] data);
        @(negedge ref_clk);
        regReq = '{wr: 1'b1, rd: 1'b0, bank: bank, addr: addr, data: data};
        @(negedge ref_clk);
        regReq = '{wr: 1'b0, rd: 1'b1, bank: bank, addr: addr, data: 16'h0000};
        @(negedge ref_clk);
        regReq = '0;
    endtask
endmodule

// file: sim/bridge_dead_time_blank_select_bench.sv
`timescale 1ns/100ps
module bridge_dead_time_blank_select_bench;
    localparam int CCP_NS   [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
    localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

    logic                      ref_clk = 1'b0;
    logic                      rst_n = 1'b0;
    bdtbs_pkg::bdtbs_reg_req_t regReq;
    bdtbs_pkg::bdtbs_ext_set_t actExtCodes = '0;
    bdtbs_pkg::bdtbs_ext_set_t fwExtCodes = '0;
    logic [7:0]                fwSel = '0;
    logic [7:0]                switchReq = '0;
    logic [7:0]                dsOvervoltage = '0;
    logic [7:0]                faultClear = '0;
    logic [15:0]               rdData_ff;
    logic [7:0]                deadActive_ff;
    logic [7:0]                blankActive_ff;
    logic [7:0]                dsFault_ff;
    int                        deadCnt [8];
    int                        blankCnt [8];
    int                        overlap;
    int                        err_count = 0;
    int                        n_checks = 0;

    always #2 ref_clk = ~ref_clk;

    bdtbs_host_model u_bdtbs_host_model (
        .ref_clk (ref_clk),
        .regReq  (regReq)
    );

    bdtbs_top u_bdtbs_top (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .regReq         (regReq),
        .actExtCodes    (actExtCodes),
        .fwExtCodes     (fwExtCodes),
        .fwSel          (fwSel),
        .switchReq      (switchReq),
        .dsOvervoltage  (dsOvervoltage),
        .faultClear     (faultClear),
        .rdData_ff      (rdData_ff),
        .deadActive_ff  (deadActive_ff),
        .blankActive_ff (blankActive_ff),
        .dsFault_ff     (dsFault_ff)
    );

    // Per-bridge lengths of the dead and blank windows, and any fault seen inside them.
    always @(posedge ref_clk) begin
        for (int i = 0; i < 8; i++) begin
            deadCnt[i] += (deadActive_ff[i] === 1'b1);
            blankCnt[i] += (blankActive_ff[i] === 1'b1);
        end
        if ((dsFault_ff & (deadActive_ff | blankActive_ff)) !== 8'h00) overlap++;
    end

    function automatic int cyc(input int ns);
        return (ns * 250 + 999) / 1000;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic rd(input logic bank, input logic [4:0] addr, input logic [15:0] exp);
        u_bdtbs_host_model.access(1'b0, bank, addr, 16'h0000);
        check(rdData_ff, exp, "register read");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    initial begin
        logic [15:0] sel;
        logic [15:0] set;
        logic [15:0] fwv;
        logic [15:0] s;
        logic [8:0]  e;
        logic [2:0]  c;
        logic [2:0]  b;
        void'($urandom(47));
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        rd(1'b0, 5'h04, 16'h0000);
        rd(1'b0, 5'h05, 16'h4924);
        rd(1'b1, 5'h05, 16'h4924);
        u_bdtbs_host_model.access(1'b1, 1'b0, 5'h07, 16'hffff);
        rd(1'b0, 5'h07, 16'h0000);
        for (int r = 0; r < 6; r++) begin
            sel = 16'($urandom);
            set = 16'($urandom) | 16'h8000;
            fwv = 16'($urandom) | 16'h8000;
            u_bdtbs_host_model.write_read(r[0], 5'h04, sel);
            check(rdData_ff, sel, "pair select write then read");
            u_bdtbs_host_model.access(1'b1, 1'b1, 5'h05, fwv);
            u_bdtbs_host_model.access(1'b1, 1'b0, 5'h05, set);
            rd(r[1], 5'h04, sel);
            rd(1'b0, 5'h05, set & 16'h7fff);
            rd(1'b1, 5'h05, fwv & 16'h7fff);
            @(negedge ref_clk);
            actExtCodes = 9'($urandom);
            fwExtCodes = 9'($urandom);
            fwSel = (r < 3) ? 8'h00 : 8'($urandom);
            deadCnt = '{default: 0};
            blankCnt = '{default: 0};
            overlap = 0;
            switchReq = 8'hff;
            // Overvoltage rises with the switch so it must stay masked until the blank window is over.
            dsOvervoltage = 8'hff;
            @(negedge ref_clk);
            switchReq = 8'h00;
            repeat (8100) @(negedge ref_clk);
            for (int n = 0; n < 8; n++) begin
                s = fwSel[n] ? fwv : set;
                e = fwSel[n] ? fwExtCodes : actExtCodes;
                case (sel[2*n +: 2])
                    2'h0: {c, b} = {s[2:0], s[5:3]};
                    2'h1: {c, b} = {s[8:6], s[11:9]};
                    2'h2: {c, b} = {s[14:12], e[2:0]};
                    default: {c, b} = {e[5:3], e[8:6]};
                endcase
                check(16'(deadCnt[n]), 16'(cyc(CCP_NS[c])), "dead length");
                check(16'(blankCnt[n]), 16'(cyc(BLANK_NS[b])), "blank length");
            end
            check({8'h00, dsFault_ff}, 16'h00ff, "fault after blank");
            check(16'(overlap), 16'h0000, "fault inside window");
            dsOvervoltage = 8'h00;
            repeat (4) @(negedge ref_clk);
            faultClear = 8'hff;
            @(negedge ref_clk);
            faultClear = 8'h00;
            @(negedge ref_clk);
            check({8'h00, dsFault_ff}, 16'h0000, "fault cleared");
        end
        // A second reset after the registers hold random values must bring back the defaults.
        rst_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        rd(1'b0, 5'h04, 16'h0000);
        rd(1'b1, 5'h05, 16'h4924);
        rd(1'b0, 5'h05, 16'h4924);
        test_done();
    end
endmodule
